/* mac_rx_pkg.sv */
// Purpose: shared constants for the port receive front end
// Assumes: mii receive path, nibble-aligned preamble, lsb-first nibbles
// Notes:   times in bit times are counted in link clock edges (4 bt each)
//
// Overview of operation
// [R1] idle port enters receive on data valid
// [R2] phy sends nibbles on 25/2.5 MHz clock; the phy model here ticks on a 160 ns link clock
// [R3] serialize nibbles, search delimiter 10101011
// [R4] bits before delimiter never reach buffer
// [R5] after delimiter forward bytes from destination
// [R6] preamble any nibble length, even none
// [R7] sender keeps at least 80 bt gap
// [R8] frames that cannot be taken are dropped
// [R9] symbol/fcs/short/runt/long/jabber frames never forwarded
// [R10] destination first bit one means multicast
// [R11] errorless frame teaches its source address
// [R12] type/length and payload pass untouched
// [R13] check trailing crc over whole frame
// [R14] up to ten ports run reversed mii
// [R15] crc mismatch: one error pulse, drop
// [R16] legal 64..1518 bytes, shorter is runt
// [R17] rx error during frame is code error
// [R18] nibble least significant bit goes first
// [R19] valid drops before delimiter: back idle
package mac_rx_pkg;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [7:0]  SFD_PATTERN   = 8'hab;   // 10101011, first bit at msb
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hdebb20e3;
  localparam int          DA_BYTES      = 6;
  localparam int          SA_BYTES      = 6;
  localparam int          MIN_FRAME_BYTES = 64;
  localparam int          MAX_FRAME_BYTES = 1518;

  // ----------------------------------------------------------------
  // times in bit times, counts in nibbles
  // ----------------------------------------------------------------
  localparam int BT_PER_NIBBLE      = 4;
  localparam int SHORT_EVENT_BT     = 76;
  localparam int SHORT_EVENT_NIB    = SHORT_EVENT_BT / BT_PER_NIBBLE;
  localparam int JABBER_BT          = 50000;
  localparam int JABBER_NIB         = JABBER_BT / BT_PER_NIBBLE;
  localparam int MIN_IFG_BT         = 80;

  // ----------------------------------------------------------------
  // reversed mii clock: 200 MHz system clock down to 25 MHz
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ        = 200;
  localparam int MII_CLK_MHZ        = 25;
  localparam int MII_HALF_DIV       = SYS_CLK_MHZ / MII_CLK_MHZ / 2;

  // ----------------------------------------------------------------
  // words crossing from link to system domain
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WK_NONE = 2'b00,
    WK_DATA = 2'b01,
    WK_END  = 2'b11
  } word_kind_t;

  localparam int XWORD_W = 10;                  // kind + byte
  localparam int OUT_W   = 10;                  // last + err + byte

  // error code bit positions of the closing status word
  localparam int ERR_CRC    = 0;
  localparam int ERR_SYMBOL = 1;
  localparam int ERR_RUNT   = 2;
  localparam int ERR_LONG   = 3;
  localparam int ERR_SHORT  = 4;
  localparam int ERR_JABBER = 5;
  localparam int ERR_ALIGN  = 6;
  localparam int ERR_OVERRUN = 7;

endpackage : mac_rx_pkg

/* rx_word_buffer.sv */
// Purpose: small shifting buffer, head entry always at a register
// Assumes: single clock, pop and push in the same cycle allowed
// Notes:   head shifts down on pop so the output needs no mux
`timescale 1ns/1ps
`default_nettype none
module rx_word_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,      // system clock
  input  wire logic             rst_b_i,    // async reset, low
  input  wire logic             in_valid_i, // word offered
  output logic                  in_ready_o, // space free
  input  wire logic [WIDTH-1:0] in_data_i,  // word in
  output logic                  out_valid_o,// head valid
  input  wire logic             out_ready_i,// sink takes head
  output logic [WIDTH-1:0]      out_data_o  // head word
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH:0]   vld_ext;
  wire              pop  = vld_reg[0] & out_ready_i;
  wire              push = in_valid_i & ~vld_reg[DEPTH-1];

  assign vld_ext     = {1'b0, vld_reg};
  assign in_ready_o  = ~vld_reg[DEPTH-1];
  assign out_valid_o = vld_reg[0];
  assign out_data_o  = mem_reg[0];

  // ----------------------------------------------------------------
  // per entry: take the next one down on pop, take new word at tail
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire              nxt_vld = pop ? vld_ext[i+1] : vld_reg[i];
    wire              prv_vld = (i == 0) ? 1'b1 : (pop ? vld_reg[i] : vld_ext[i-1+((i==0)?1:0)]);
    wire              is_tail = ~nxt_vld & prv_vld;
    wire [WIDTH-1:0]  nxt_dat = (pop && i < DEPTH-1) ? mem_reg[(i < DEPTH-1) ? i+1 : i]
                                                     : mem_reg[i];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        vld_reg[i] <= 1'b0;
        mem_reg[i] <= '0;
      end else if (push && is_tail) begin
        vld_reg[i] <= 1'b1;
        mem_reg[i] <= in_data_i;
      end else begin
        vld_reg[i] <= nxt_vld;
        mem_reg[i] <= nxt_dat;
      end
    end
  end

endmodule : rx_word_buffer
`default_nettype wire

/* port_rx_mac.sv */
// Purpose: receive front end of one switch port mac
// Assumes: mii receive signals are synchronous to mii_rx_clk_i
// Notes:   closing word of each frame is a status word, not a frame byte
`timescale 1ns/1ps
`default_nettype none
module port_rx_mac #(
  parameter int          JABBER_NIBBLES = mac_rx_pkg::JABBER_NIB,
  parameter int          MAX_BYTES      = mac_rx_pkg::MAX_FRAME_BYTES,
  parameter int          BUF_DEPTH      = 2
) (
  input  wire logic        clk_i,            // system clock, 200 MHz
  input  wire logic        rst_b_i,          // async reset, low
  input  wire logic        mii_rx_clk_i,     // link receive clock
  input  wire logic        mii_rx_dv_i,      // receive data valid
  input  wire logic        mii_rx_er_i,      // receive error
  input  wire logic [3:0]  mii_rxd_i,        // receive nibble
  input  wire logic        rev_mode_i,       // reversed mii strap
  output logic             mii_clk_o,        // clock driven in reversed mode
  output logic             mii_clk_oe_b_o,   // low while driving mii_clk_o
  output logic             out_valid_o,      // buffer word valid
  input  wire logic        out_ready_i,      // switch buffer takes word
  output logic [7:0]       out_data_o,       // frame byte or status code
  output logic             out_last_o,       // status word ends frame
  output logic             out_err_o,        // frame must be dropped
  output logic             learn_o,          // pulse: source address learned
  output logic [47:0]      learned_sa_o,     // port's learned address
  output logic             mcast_o,          // last good frame was multicast
  output logic             frame_err_led_o,  // pulse on crc mismatch
  output logic [7:0]       err_code_o        // error code of last frame
);
  import mac_rx_pkg::*;

  // ----------------------------------------------------------------
  // link domain reset: assert at once, release on link clock
  // ----------------------------------------------------------------
  logic lk_rst_s1_reg;
  logic lk_rst_b_reg;

  always_ff @(posedge mii_rx_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_rst_s1_reg <= 1'b0;
      lk_rst_b_reg  <= 1'b0;
    end else begin
      lk_rst_s1_reg <= 1'b1;
      lk_rst_b_reg  <= lk_rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // link side receive state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HUNT = 2'b01,
    ST_DATA = 2'b11,
    ST_DROP = 2'b10
  } rx_state_t;

  rx_state_t    st_reg,   st_next;
  logic [7:0]   hist_reg;
  logic [7:0]   hist_next;
  logic [3:0]   lo_nib_reg;
  logic         half_reg;
  logic [31:0]  crc_reg;
  logic [31:0]  crc_next;
  logic [31:0]  crc_byte_reg;
  logic [10:0]  bytes_reg;
  logic [15:0]  dv_nib_reg;
  logic         sym_err_reg;
  logic         long_err_reg;
  logic [XWORD_W-1:0] lk_word_reg;
  logic         lk_tog_reg;

  function automatic logic [31:0] crc_nibble(input logic [31:0] c, input logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int b = 0; b < 4; b++) begin
      r = (r[0] ^ n[b]) ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1); // R13 R15 R18
    end
    return r;
  endfunction : crc_nibble

  // delimiter window: each bit shifts in at lsb, lsb of nibble first
  assign hist_next = {hist_reg[3:0], mii_rxd_i[0], mii_rxd_i[1],
                      mii_rxd_i[2], mii_rxd_i[3]};                 // R3 R18
  assign crc_next  = crc_nibble(crc_reg, mii_rxd_i);

  wire        sfd_hit     = (hist_next == SFD_PATTERN);            // R3 R6
  wire        byte_done   = mii_rx_dv_i & half_reg;
  wire [7:0]  rx_byte     = {mii_rxd_i, lo_nib_reg};               // R18
  wire        jabber_hit  = (dv_nib_reg >= 16'(JABBER_NIBBLES));
  wire [10:0] bytes_inc   = (bytes_reg == 11'h7ff) ? bytes_reg : bytes_reg + 11'h001;
  wire        runt_err    = (bytes_reg < 11'(MIN_FRAME_BYTES));    // R16
  wire        short_err   = (dv_nib_reg < 16'(SHORT_EVENT_NIB));
  // judged on whole bytes only: a dribble nibble is no part of the check
  wire        crc_err     = (crc_byte_reg != CRC_RESIDUE);         // R13 R15
  wire [7:0]  end_code    = {1'b0, half_reg, jabber_hit, short_err, long_err_reg,
                             runt_err, sym_err_reg, crc_err};      // R9

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: if (mii_rx_dv_i) st_next = sfd_hit ? ST_DATA : ST_HUNT; // R1 R6
      ST_HUNT: begin
        if (!mii_rx_dv_i)  st_next = ST_IDLE;                      // R19
        else if (sfd_hit)  st_next = ST_DATA;                      // R5
      end
      ST_DATA: begin
        if (!mii_rx_dv_i)  st_next = ST_IDLE;
        else if (jabber_hit) st_next = ST_DROP;                    // R9
      end
      ST_DROP: if (!mii_rx_dv_i) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  wire in_frame  = (st_reg == ST_DATA);
  wire send_data = in_frame & byte_done & ~jabber_hit;             // R5 R12
  wire send_end  = in_frame & (~mii_rx_dv_i | jabber_hit);

  always_ff @(posedge mii_rx_clk_i or negedge lk_rst_b_reg) begin
    if (!lk_rst_b_reg) begin
      st_reg       <= ST_IDLE;
      hist_reg     <= 8'h00;
      lo_nib_reg   <= 4'h0;
      half_reg     <= 1'b0;
      crc_reg      <= CRC_INIT;
      crc_byte_reg <= CRC_INIT;
      bytes_reg    <= 11'h000;
      dv_nib_reg   <= 16'h0000;
      sym_err_reg  <= 1'b0;
      long_err_reg <= 1'b0;
      lk_word_reg  <= '0;
      lk_tog_reg   <= 1'b0;
    end else begin
      st_reg <= st_next;
      // hunting state only looks for the delimiter, no byte is kept
      hist_reg <= mii_rx_dv_i ? hist_next : 8'h00;                 // R4
      if (!mii_rx_dv_i) begin
        dv_nib_reg <= 16'h0000;
      end else if (!jabber_hit) begin
        dv_nib_reg <= dv_nib_reg + 16'h0001;
      end
      if (!in_frame) begin
        half_reg     <= 1'b0;
        crc_reg      <= CRC_INIT;
        crc_byte_reg <= CRC_INIT;
        bytes_reg    <= 11'h000;
        sym_err_reg  <= mii_rx_dv_i & mii_rx_er_i;
        long_err_reg <= 1'b0;
      end else if (mii_rx_dv_i) begin
        half_reg   <= ~half_reg;
        lo_nib_reg <= mii_rxd_i;
        crc_reg    <= crc_next;                                    // R13
        if (mii_rx_er_i) sym_err_reg <= 1'b1;                      // R17
        if (byte_done) begin
          bytes_reg <= bytes_inc;
          crc_byte_reg <= crc_next;                                // R13
          if (bytes_inc > 11'(MAX_BYTES)) long_err_reg <= 1'b1;    // R16
        end
      end
      if (send_data) begin
        lk_word_reg <= {WK_DATA, rx_byte};
        lk_tog_reg  <= ~lk_tog_reg;
      end else if (send_end) begin
        lk_word_reg <= {WK_END, end_code};                         // R9
        lk_tog_reg  <= ~lk_tog_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // crossing: toggle through two flops, word held stable meanwhile
  // ----------------------------------------------------------------
  // limitation: word lives at least one link clock, far longer than the
  // three system edges the toggle needs, so no return path is kept
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic rev_s1_reg;
  logic rev_s2_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      rev_s1_reg <= 1'b0;
      rev_s2_reg <= 1'b0;
    end else begin
      tog_s1_reg <= lk_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      rev_s1_reg <= rev_mode_i;
      rev_s2_reg <= rev_s1_reg;
    end
  end

  wire                word_arrive = tog_s2_reg ^ tog_s3_reg;
  wire [1:0]          arr_kind    = lk_word_reg[9:8];
  wire [7:0]          arr_byte    = lk_word_reg[7:0];

  // ----------------------------------------------------------------
  // system side: pending word, overrun, field capture
  // ----------------------------------------------------------------
  logic               pend_reg;
  logic [XWORD_W-1:0] pend_word_reg;
  logic               ovr_reg;
  logic [3:0]         fidx_reg;
  logic               da_grp_reg;
  logic [47:0]        sa_reg;
  logic               buf_ready;
  logic               buf_valid;
  logic [OUT_W-1:0]   buf_data;

  wire       pend_end  = (pend_word_reg[9:8] == WK_END);
  wire       pend_push = pend_reg & buf_ready;
  // a pending word that cannot leave is lost when the next one lands on it
  wire       ovr_set   = word_arrive & pend_reg & ~buf_ready;      // R8
  wire       ovr_clr   = pend_push & pend_end;
  wire [7:0] pend_code = {ovr_reg, pend_word_reg[6:0]};
  wire       pend_bad  = (pend_code != 8'h00);                     // R9
  wire [OUT_W-1:0] buf_in = pend_end ? {1'b1, pend_bad, pend_code}
                                     : {1'b0, 1'b0, pend_word_reg[7:0]};
  wire       fld_data  = word_arrive & (arr_kind == WK_DATA);
  wire       fld_end   = word_arrive & (arr_kind == WK_END);
  wire       frame_ok  = fld_end & (arr_byte == 8'h00) & ~ovr_reg & ~ovr_set;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg      <= 1'b0;
      pend_word_reg <= '0;
      ovr_reg       <= 1'b0;
    end else begin
      if (word_arrive) begin
        pend_reg      <= 1'b1;
        pend_word_reg <= lk_word_reg;
      end else if (pend_push) begin
        pend_reg      <= 1'b0;
      end
      ovr_reg <= (ovr_reg & ~ovr_clr) | ovr_set;                   // R8
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fidx_reg        <= 4'h0;
      da_grp_reg      <= 1'b0;
      sa_reg          <= 48'h0;
      learn_o         <= 1'b0;
      learned_sa_o    <= 48'h0;
      mcast_o         <= 1'b0;
      frame_err_led_o <= 1'b0;
      err_code_o      <= 8'h00;
    end else begin
      learn_o         <= frame_ok;                                 // R11
      frame_err_led_o <= fld_end & arr_byte[ERR_CRC];              // R15
      if (fld_data) begin
        if (fidx_reg == 4'h0) da_grp_reg <= arr_byte[0];           // R10
        if (fidx_reg >= 4'(DA_BYTES) && fidx_reg < 4'(DA_BYTES + SA_BYTES)) begin
          sa_reg <= {arr_byte, sa_reg[47:8]};                      // R11
        end
        if (fidx_reg != 4'hf) fidx_reg <= fidx_reg + 4'h1;
      end
      if (fld_end) begin
        fidx_reg   <= 4'h0;
        err_code_o <= {ovr_reg | ovr_set, arr_byte[6:0]};
      end
      if (frame_ok) begin
        learned_sa_o <= sa_reg;                                    // R11
        mcast_o      <= da_grp_reg;                                // R10
      end
    end
  end

  rx_word_buffer #(
    .WIDTH (OUT_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (pend_reg),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_valid),
    .out_ready_i (out_ready_i),
    .out_data_o  (buf_data)
  );

  assign out_valid_o = buf_valid;
  assign out_last_o  = buf_data[9];
  assign out_err_o   = buf_data[8];
  assign out_data_o  = buf_data[7:0];

  // ----------------------------------------------------------------
  // reversed mii: port drives the clock toward an attached mac
  // ----------------------------------------------------------------
  logic [2:0] div_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg        <= 3'h0;
      mii_clk_o      <= 1'b0;
      mii_clk_oe_b_o <= 1'b1;
    end else begin
      mii_clk_oe_b_o <= ~rev_s2_reg;                               // R14
      if (!rev_s2_reg) begin
        div_reg   <= 3'h0;
        mii_clk_o <= 1'b0;
      end else if (div_reg == 3'(MII_HALF_DIV - 1)) begin
        div_reg   <= 3'h0;
        mii_clk_o <= ~mii_clk_o;                                   // R14
      end else begin
        div_reg   <= div_reg + 3'h1;
      end
    end
  end

endmodule : port_rx_mac
`default_nettype wire

/* port_rx_mac_assertions.sv */
// Purpose: port-level checks of the port receive front end
// Assumes: system clock domain only; reversed strap stays high once set
// Notes:   link-side timing is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module port_rx_mac_assertions (
  input wire logic        clk_i,           // system clock
  input wire logic        rst_b_i,         // async reset, low
  input wire logic        rev_mode_i,      // reversed strap
  input wire logic        out_ready_i,     // sink ready
  input wire logic        out_valid_o,     // word valid
  input wire logic [7:0]  out_data_o,      // byte or code
  input wire logic        out_last_o,      // status word
  input wire logic        out_err_o,       // drop flag
  input wire logic        learn_o,         // learn pulse
  input wire logic [47:0] learned_sa_o,    // learned address
  input wire logic        mcast_o,         // multicast flag
  input wire logic        frame_err_led_o, // crc pulse
  input wire logic        mii_clk_o,       // reversed clock
  input wire logic        mii_clk_oe_b_o   // clock enable, low
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  learn_pulse_a: assert property (learn_o |=> !learn_o)
    else $error("learn pulse longer than one cycle");
  sa_update_a: assert property ($changed(learned_sa_o) |-> learn_o)
    else $error("learned address moved without learn pulse");
  mcast_update_a: assert property ($changed(mcast_o) |-> learn_o)
    else $error("multicast flag moved without good frame");
  led_pulse_a: assert property (frame_err_led_o |=> !frame_err_led_o)
    else $error("crc indicator pulse too long");
  status_err_a: assert property (out_valid_o && out_last_o |-> out_err_o == (out_data_o != 8'h00))
    else $error("drop flag disagrees with status code");
  word_hold_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable({out_data_o, out_last_o, out_err_o}))
    else $error("offered word lost or changed under stall");
  clk_half_a: assert property ($rose(mii_clk_o) |-> mii_clk_o [*4] ##1 !mii_clk_o)
    else $error("reversed clock half period wrong");
  clk_off_a: assert property (!rev_mode_i [*5] |-> mii_clk_oe_b_o && !mii_clk_o)
    else $error("clock driven outside reversed mode");
  clk_drive_a: assert property (rev_mode_i [*5] |-> !mii_clk_oe_b_o)
    else $error("clock not driven in reversed mode");

  cover property (learn_o);
  cover property (frame_err_led_o);
  cover property (out_valid_o && out_last_o && out_err_o && !out_ready_i);
endmodule : port_rx_mac_assertions

bind port_rx_mac port_rx_mac_assertions port_rx_mac_assertions_i (.clk_i, .rst_b_i,
  .rev_mode_i, .out_ready_i, .out_valid_o, .out_data_o, .out_last_o, .out_err_o,
  .learn_o, .learned_sa_o, .mcast_o, .frame_err_led_o, .mii_clk_o, .mii_clk_oe_b_o);
`default_nettype wire

/* mii_phy_model.sv */
// Purpose: transceiver side of the mii receive path
// Assumes: 160 ns link clock, made only while tick runs: for a frame, its gap, or the bench's two reset ticks
// Notes:   idle data lines invert every tick so no stale value survives
`timescale 1ns/1ps
`default_nettype none
module mii_phy_model (
  output logic       rx_clk_o, // link clock
  output logic       rx_dv_o,  // data valid
  output logic       rx_er_o,  // receive error
  output logic [3:0] rxd_o     // nibble
);
  initial begin
    rx_clk_o = 1'b0;
    rx_dv_o = 1'b0;
    rx_er_o = 1'b0;
    rxd_o = 4'h0;
  end

  // one link period; lines move just after the rising edge
  task automatic tick(input logic dv, input logic er, input logic [3:0] d);
    #80 rx_clk_o = 1'b1;
    #1 rx_dv_o = dv;
    rx_er_o = er;
    rxd_o = dv ? d : ~rxd_o;
    #79 rx_clk_o = 1'b0;
  endtask : tick

  // er_at -1 puts an error in the idle lead, -2 means none
  task automatic send(input logic [7:0] b[$], input int pre, input int er_at,
                      input bit odd, input bit sfd);
    logic [3:0] nib[$];
    nib = {};
    repeat (pre) nib.push_back(4'h5);
    if (sfd) begin
      nib.push_back(4'h5);
      nib.push_back(4'hd);
    end
    foreach (b[i]) begin
      nib.push_back(b[i][3:0]);
      nib.push_back(b[i][7:4]);
    end
    if (odd) nib.push_back(4'h3);
    for (int i = 0; i < 4; i++) tick(1'b0, er_at == -1 && i == 1, 4'h0);
    foreach (nib[i]) tick(1'b1, er_at == i, nib[i]);
    repeat (24) tick(1'b0, 1'b0, 4'h0);
  endtask : send
endmodule : mii_phy_model
`default_nettype wire

/* port_rx_mac_tb.sv */
// Purpose: self-checking bench of the port receive front end
// Assumes: one frame in flight at a time, sink stalls at random
// Notes:   jabber frames are judged on their status word only
`timescale 1ns/1ps
`default_nettype none
module port_rx_mac_tb;
  import mac_rx_pkg::*;
  typedef logic [7:0] bq_t[$];
  localparam int JAB = 300;
  localparam int MAXB = 100;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rev_mode_i = 1'b0;
  logic        out_ready_i = 1'b0;
  logic        rx_clk, rx_dv, rx_er, out_valid_o, out_last_o, out_err_o;
  logic        learn_o, mcast_o, led, mii_clk_o, oe_b, loose = 1'b0, p, stall = 1'b0;
  bq_t         sq;
  logic [3:0]  rxd;
  logic [7:0]  out_data_o, err_code_o;
  logic [47:0] learned_sa_o;
  logic [9:0]  expq[$];
  int          miscompares = 0, total_checks = 0, cycles = 0, leds = 0, ledexp = 0;
  int          lbit = ERR_JABBER;

  mii_phy_model mii_phy_model_i (.rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
    .rxd_o(rxd));
  port_rx_mac #(.JABBER_NIBBLES(JAB), .MAX_BYTES(MAXB)) port_rx_mac_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .mii_rx_clk_i(rx_clk), .mii_rx_dv_i(rx_dv), .mii_rx_er_i(rx_er),
    .mii_rxd_i(rxd), .rev_mode_i(rev_mode_i), .mii_clk_o(mii_clk_o),
    .mii_clk_oe_b_o(oe_b), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_data_o(out_data_o), .out_last_o(out_last_o), .out_err_o(out_err_o),
    .learn_o(learn_o), .learned_sa_o(learned_sa_o), .mcast_o(mcast_o),
    .frame_err_led_o(led), .err_code_o(err_code_o));

  always #2.5 clk_i = ~clk_i;

  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] crc_of(bq_t b);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (b[i]) for (int k = 0; k < 8; k++)
      c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 32'hedb88320 : 32'h0);
    return ~c;
  endfunction : crc_of

  // ----------------------------------------------------------------
  // sink with random stalls, word compare, hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    out_ready_i <= !stall && (($urandom % 4) != 0);
    cycles++;
    if (led === 1'b1) leds++;
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      if (loose && out_last_o === 1'b1) begin
        chk("loose status", 2'b11, {out_err_o, out_data_o[lbit]});
        loose = 1'b0;
      end else if (!loose)
        chk("out word", expq.size() ? expq.pop_front() : 10'h3ff,
            {out_last_o, out_err_o, out_data_o});
    end
    if (cycles == 90000) begin
      miscompares++;
      test_done();
    end
  end

  // n body bytes before the check field
  task automatic run(input int n, input int pre, input int er_at, input bit odd,
                     input bit bad);
    bq_t b;
    logic [31:0] f;
    logic [7:0] code;
    logic [47:0] sa;
    logic mc;
    bit jb;
    b = {};
    for (int i = 0; i < n; i++) b.push_back(8'($urandom));
    f = crc_of(b) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) b.push_back(f[8*i +: 8]);
    code = {1'b0, 1'(odd), 1'b0, 1'((pre + 2 + 2 * b.size() + odd) < 19),
            1'(b.size() > MAXB), 1'(b.size() < MIN_FRAME_BYTES), 1'(er_at >= 0), 1'(bad)};
    jb = (pre + 2 + 2 * b.size() + odd) > JAB;
    sa = code == 8'h00 ? {b[11], b[10], b[9], b[8], b[7], b[6]} : learned_sa_o;
    mc = code == 8'h00 ? b[0][0] : mcast_o;
    ledexp += bad;
    if (jb)
      loose = 1'b1;
    else begin
      foreach (b[i]) expq.push_back({2'b00, b[i]});
      expq.push_back({1'b1, code != 8'h00, code});
    end
    mii_phy_model_i.send(b, pre, er_at, odd, 1'b1);
    for (int i = 0; i < 3000 && (expq.size() != 0 || loose); i++) @(posedge clk_i);
    chk("frame drained", 0, expq.size() != 0 || loose);
    chk("learned sa", sa, learned_sa_o);
    chk("multicast", mc, mcast_o);
    if (jb) ledexp = leds;
    else chk("error code", code, err_code_o);
    chk("crc pulses", ledexp, leds);
  endtask : run

  initial begin
    void'($urandom(32'h2ad30638));
    repeat (2) mii_phy_model_i.tick(1'b0, 1'b0, 4'h0);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk("clock enable idle", 1, oe_b);
    mii_phy_model_i.send(sq, 6, -1, 1'b0, 1'b0);
    repeat (50) @(posedge clk_i);
    chk("abort quiet", 0, out_valid_o);
    run(60, 0, -2, 1'b0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      int pre;
      pre = $urandom % 16;
      run(60 + $urandom % 10, pre, i == 2 ? pre + 12 : (i == 4 ? -1 : -2), i == 3,
          i == 1);
    end
    run(44, 3, -2, 1'b0, 1'b0);
    run(4, 0, -2, 1'b0, 1'b0);
    run(100, 1, -2, 1'b0, 1'b0);
    run(160, 2, -2, 1'b0, 1'b0);
    run(62, 0, -2, 1'b0, 1'b0);
    // sink frozen for a whole frame: words are lost, status must say so
    sq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    lbit = ERR_OVERRUN;
    loose = 1'b1;
    stall = 1'b1;
    mii_phy_model_i.send(sq, 2, -2, 1'b0, 1'b1);
    stall = 1'b0;
    for (int i = 0; i < 3000 && loose; i++) @(posedge clk_i);
    chk("overrun drained", 0, loose);
    chk("overrun code", 1, err_code_o[ERR_OVERRUN]);
    rev_mode_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("clock enable driven", 0, oe_b);
    p = mii_clk_o;
    ledexp = 0;
    repeat (64) begin
      @(negedge clk_i);
      if (mii_clk_o === 1'b1 && p === 1'b0) ledexp++;
      p = mii_clk_o;
    end
    chk("reversed clock rises", 8, ledexp);
    test_done();
  end
endmodule : port_rx_mac_tb
`default_nettype wire
